/* File: design/rals_pkg.sv */
package rals_pkg;
  // register offsets on the serial control bus
  localparam logic [7:0]  ADDR_TARGET     = 8'h07;
  localparam logic [7:0]  ADDR_ALIAS      = 8'h08;
  localparam logic [7:0]  ADDR_CNT_LOW    = 8'h0A;
  localparam logic [7:0]  ADDR_CNT_HIGH   = 8'h0B;
  localparam logic [7:0]  ADDR_STATUS     = 8'h0C;
  // address field sits in bits 7:1, bit 0 reserved
  localparam int          ADDR_FIELD_MSB  = 7;
  localparam int          ADDR_FIELD_LSB  = 1;
  // status bit positions
  localparam int          ST_LINK_LOST    = 4;
  localparam int          ST_SELFTEST_ERR = 3;
  localparam int          ST_CLOCK        = 2;
  localparam int          ST_CRC_ERR      = 1;
  localparam int          ST_LINK         = 0;
  // reset values and counter saturation value
  localparam logic [6:0]  ADDR_RESET      = 7'h00;
  localparam logic [15:0] CNT_RESET       = 16'h0000;
  localparam logic [15:0] CNT_MAX         = 16'hFFFF;
  localparam logic [7:0]  RDATA_RESET     = 8'h00;
  // number of link ports
  localparam int          NUM_PORTS       = 2;
endpackage

/* File: design/rals_port_bank.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// one link port's copy of target, alias, error counter and status flags
module rals_port_bank (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        wr_target,          // store write data as target
  input  wire logic        wr_alias,           // store write data as alias
  input  wire logic [6:0]  wdata,              // address field of write data
  input  wire logic        link_detect,        // cable link present, level
  input  wire logic        crc_error,          // normal-mode crc error, pulse
  input  wire logic        selftest_crc_error, // self-test crc error, pulse
  input  wire logic        selftest_restart,   // self-test restart, pulse
  input  wire logic        count_clear,        // counter-reset level
  output logic [6:0]       target,             // remote target address
  output logic [6:0]       alias_addr,         // local alias address
  output logic [15:0]      count,              // back-channel crc error count
  output logic             link_lost,          // sticky link-lost flag
  output logic             selftest_err,       // self-test crc error flag
  output logic             crc_err,            // normal-mode crc error flag
  output logic             link_present        // registered link detect
);
  logic [6:0]  next_target;
  logic [6:0]  next_alias_addr;
  logic [15:0] next_count;
  logic        next_link_lost;
  logic        next_selftest_err;
  logic        next_crc_err;
  logic        link_loss;                      // falling edge of link detect

  ////////////////////////////////////////////////////////////////////////////
  // next-state for the port's registers
  always_comb begin
    link_loss         = link_present & ~link_detect;
    next_target       = wr_target ? wdata : target;
    next_alias_addr   = wr_alias ? wdata : alias_addr;
    next_count        = count;
    // counter is held at zero while the reset level stands
    if (count_clear) begin
      next_count = rals_pkg::CNT_RESET;
    end else if ((crc_error | selftest_crc_error) && count != rals_pkg::CNT_MAX) begin
      next_count = count + 16'h0001;
    end
    // set wins over clear so an event in the clearing cycle is kept
    next_link_lost    = link_loss | (link_lost & ~count_clear);
    next_selftest_err = selftest_crc_error |
                        (selftest_err & ~(link_loss | selftest_restart | count_clear));
    next_crc_err      = crc_error | (crc_err & ~(link_loss | count_clear));
  end

  ////////////////////////////////////////////////////////////////////////////
  // register stage
  always_ff @(posedge clk) begin
    if (!resetn) begin
      target       <= rals_pkg::ADDR_RESET;
      alias_addr   <= rals_pkg::ADDR_RESET;
      count        <= rals_pkg::CNT_RESET;
      link_lost    <= 1'b0;
      selftest_err <= 1'b0;
      crc_err      <= 1'b0;
      link_present <= 1'b0;
    end else begin
      target       <= next_target;
      alias_addr   <= next_alias_addr;
      count        <= next_count;
      link_lost    <= next_link_lost;
      selftest_err <= next_selftest_err;
      crc_err      <= next_crc_err;
      link_present <= link_detect;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_cnt_clear;
    @(posedge clk) disable iff (!resetn) count_clear |=> count == rals_pkg::CNT_RESET;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared");

  property p_cnt_inc;
    @(posedge clk) disable iff (!resetn)
      (crc_error || selftest_crc_error) && !count_clear && count != rals_pkg::CNT_MAX
      |=> count == $past(count) + 16'h0001;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("counter missed an error");

  property p_cnt_sat;
    @(posedge clk) disable iff (!resetn)
      count == rals_pkg::CNT_MAX && !count_clear |=> count == rals_pkg::CNT_MAX;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) else $error("counter wrapped");

  property p_link_lost_sticky;
    @(posedge clk) disable iff (!resetn)
      (link_present && !link_detect) ##1 !count_clear [*3] |=> link_lost;
  endproperty
  a_link_lost_sticky: assert property (p_link_lost_sticky) else $error("link lost flag dropped");

  property p_selftest_clear;
    @(posedge clk) disable iff (!resetn)
      !selftest_crc_error && (selftest_restart || count_clear) |=> !selftest_err;
  endproperty
  a_selftest_clear: assert property (p_selftest_clear) else $error("self-test flag not cleared");

  property p_crc_flag;
    @(posedge clk) disable iff (!resetn)
      crc_error |=> crc_err ##0 count != rals_pkg::CNT_RESET || $past(count_clear);
  endproperty
  a_crc_flag: assert property (p_crc_flag) else $error("crc error flag not set");

  property p_link_follow;
    @(posedge clk) disable iff (!resetn) 1'b1 |=> link_present == $past(link_detect);
  endproperty
  a_link_follow: assert property (p_link_follow) else $error("link detect not followed");
endmodule

/* File: design/rals_regs.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module rals_regs (
  input  wire logic        SYS_CLK,             // 200 MHz system clock
  input  wire logic        RESETN,              // synchronous reset, active low
  input  wire logic [7:0]  REG_ADDR,            // register offset
  input  wire logic        REG_WR,              // write strobe, one cycle
  input  wire logic        REG_RD,              // read strobe, one cycle
  input  wire logic [7:0]  REG_WDATA,           // write data
  output logic [7:0]       REG_RDATA,           // read data, valid cycle after strobe
  input  wire logic        CRC_COUNT_RESET,     // counter-reset control bit level
  input  wire logic        SECOND_PORT_SELECT,  // port-select control bit level
  input  wire logic        INPUT_CLOCK_PRESENT, // valid video input clock level
  input  wire logic [1:0]  LINK_DETECT,         // per-port link detect level
  input  wire logic [1:0]  BC_CRC_ERROR,        // per-port normal crc error pulse
  input  wire logic [1:0]  SELFTEST_CRC_ERROR,  // per-port self-test crc error pulse
  input  wire logic [1:0]  SELFTEST_RESTART,    // per-port self-test restart pulse
  input  wire logic        TXN_VALID,           // local transaction address valid
  input  wire logic [6:0]  TXN_ADDR,            // local transaction 7-bit address
  output logic             FWD_VALID,           // forward request, one cycle
  output logic [6:0]       FWD_ADDR,            // remapped remote address
  output logic             FWD_PORT,            // port that forwards it
  output logic             FWD_MISS             // no enabled alias matched, one cycle
);
  localparam int NP = rals_pkg::NUM_PORTS;

  // per-port bank outputs
  logic [6:0]  bank_target [NP];
  logic [6:0]  bank_alias  [NP];
  logic [15:0] bank_count  [NP];
  logic [NP-1:0] bank_link_lost;
  logic [NP-1:0] bank_selftest_err;
  logic [NP-1:0] bank_crc_err;
  logic [NP-1:0] bank_link;
  logic [NP-1:0] wr_target;                     // write to target of a port
  logic [NP-1:0] wr_alias;                      // write to alias of a port
  logic [NP-1:0] port_hit;                      // enabled alias equals request
  logic [NP-1:0] port_enabled;                  // both address fields nonzero

  // next values
  logic [7:0]  next_rdata;
  logic        next_fwd_valid;
  logic [6:0]  next_fwd_addr;
  logic        next_fwd_port;
  logic        next_fwd_miss;
  logic        sel;                             // selected port index

  // helper copies for checks
  logic [6:0]  target0;
  logic [6:0]  alias0;
  logic [6:0]  target1;
  logic [6:0]  alias1;

  ////////////////////////////////////////////////////////////////////////////
  // decode a banked register write for one port
  function automatic logic bank_write(input logic [7:0] addr, input logic [7:0] offset,
                                      input logic sel_bit, input logic port);
    bank_write = (addr == offset) && (sel_bit == port);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // per-port register banks and their write and match decode
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_port
      always_comb begin
        // the port index is cut to one bit on purpose, two ports only
        wr_target[gp]    = REG_WR & bank_write(REG_ADDR, rals_pkg::ADDR_TARGET,
                                               SECOND_PORT_SELECT, 1'(gp));
        wr_alias[gp]     = REG_WR & bank_write(REG_ADDR, rals_pkg::ADDR_ALIAS,
                                               SECOND_PORT_SELECT, 1'(gp));
        // zero in either field disables the remote target
        port_enabled[gp] = (bank_target[gp] != rals_pkg::ADDR_RESET) &&
                           (bank_alias[gp] != rals_pkg::ADDR_RESET);
        port_hit[gp]     = port_enabled[gp] && (bank_alias[gp] == TXN_ADDR);
      end
      rals_port_bank u_bank (
        .clk                (SYS_CLK),
        .resetn             (RESETN),
        .wr_target          (wr_target[gp]),
        .wr_alias           (wr_alias[gp]),
        .wdata              (REG_WDATA[rals_pkg::ADDR_FIELD_MSB:rals_pkg::ADDR_FIELD_LSB]),
        .link_detect        (LINK_DETECT[gp]),
        .crc_error          (BC_CRC_ERROR[gp]),
        .selftest_crc_error (SELFTEST_CRC_ERROR[gp]),
        .selftest_restart   (SELFTEST_RESTART[gp]),
        .count_clear        (CRC_COUNT_RESET),
        .target             (bank_target[gp]),
        .alias_addr         (bank_alias[gp]),
        .count              (bank_count[gp]),
        .link_lost          (bank_link_lost[gp]),
        .selftest_err       (bank_selftest_err[gp]),
        .crc_err            (bank_crc_err[gp]),
        .link_present       (bank_link[gp])
      );
    end
  endgenerate

  assign target0 = bank_target[0];
  assign alias0  = bank_alias[0];
  assign target1 = bank_target[1];
  assign alias1  = bank_alias[1];

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped offsets read zero, reserved bits read zero
  always_comb begin
    sel        = SECOND_PORT_SELECT;
    next_rdata = REG_RDATA;
    if (REG_RD) begin
      next_rdata = rals_pkg::RDATA_RESET;
      unique case (REG_ADDR)
        rals_pkg::ADDR_TARGET: begin
          next_rdata[rals_pkg::ADDR_FIELD_MSB:rals_pkg::ADDR_FIELD_LSB] =
            bank_target[sel];
        end
        rals_pkg::ADDR_ALIAS: begin
          next_rdata[rals_pkg::ADDR_FIELD_MSB:rals_pkg::ADDR_FIELD_LSB] =
            bank_alias[sel];
        end
        rals_pkg::ADDR_CNT_LOW: begin
          next_rdata = bank_count[sel][7:0];
        end
        rals_pkg::ADDR_CNT_HIGH: begin
          next_rdata = bank_count[sel][15:8];
        end
        rals_pkg::ADDR_STATUS: begin
          next_rdata[rals_pkg::ST_LINK_LOST]    = bank_link_lost[sel];
          next_rdata[rals_pkg::ST_SELFTEST_ERR] = bank_selftest_err[sel];
          // clock detect is shared, never banked
          next_rdata[rals_pkg::ST_CLOCK]        = INPUT_CLOCK_PRESENT;
          next_rdata[rals_pkg::ST_CRC_ERR]      = bank_crc_err[sel];
          next_rdata[rals_pkg::ST_LINK]         = bank_link[sel];
        end
        default: begin
          next_rdata = rals_pkg::RDATA_RESET;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alias remap; port 0 wins when both aliases match the same address
  always_comb begin
    next_fwd_valid = TXN_VALID & (|port_hit);
    next_fwd_miss  = TXN_VALID & ~(|port_hit);
    next_fwd_port  = FWD_PORT;
    next_fwd_addr  = FWD_ADDR;
    if (TXN_VALID && port_hit[0]) begin
      next_fwd_port = 1'b0;
      next_fwd_addr = bank_target[0];
    end else if (TXN_VALID && port_hit[1]) begin
      next_fwd_port = 1'b1;
      next_fwd_addr = bank_target[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output registers
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      REG_RDATA <= rals_pkg::RDATA_RESET;
      FWD_VALID <= 1'b0;
      FWD_ADDR  <= rals_pkg::ADDR_RESET;
      FWD_PORT  <= 1'b0;
      FWD_MISS  <= 1'b0;
    end else begin
      REG_RDATA <= next_rdata;
      FWD_VALID <= next_fwd_valid;
      FWD_ADDR  <= next_fwd_addr;
      FWD_PORT  <= next_fwd_port;
      FWD_MISS  <= next_fwd_miss;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_write_target;
    @(posedge SYS_CLK) disable iff (!RESETN)
      REG_WR && REG_ADDR == rals_pkg::ADDR_TARGET && !SECOND_PORT_SELECT
      |=> target0 == $past(REG_WDATA[7:1]);
  endproperty
  a_write_target: assert property (p_write_target) else $error("target not stored");

  property p_write_alias;
    @(posedge SYS_CLK) disable iff (!RESETN)
      REG_WR && REG_ADDR == rals_pkg::ADDR_ALIAS && SECOND_PORT_SELECT
      |=> alias1 == $past(REG_WDATA[7:1]);
  endproperty
  a_write_alias: assert property (p_write_alias) else $error("alias not stored in port 1");

  property p_remap;
    @(posedge SYS_CLK) disable iff (!RESETN)
      TXN_VALID && TXN_ADDR == alias0 && alias0 != 7'h00 && target0 != 7'h00
      |=> FWD_VALID && !FWD_PORT && FWD_ADDR == $past(target0);
  endproperty
  a_remap: assert property (p_remap) else $error("alias not remapped to target");

  property p_refuse_zero;
    @(posedge SYS_CLK) disable iff (!RESETN)
      TXN_VALID && (target0 == 7'h00 || alias0 == 7'h00) &&
      (target1 == 7'h00 || alias1 == 7'h00) |=> !FWD_VALID && FWD_MISS;
  endproperty
  a_refuse_zero: assert property (p_refuse_zero) else $error("forwarded with zero field");

  property p_clock_bit;
    @(posedge SYS_CLK) disable iff (!RESETN)
      REG_RD && REG_ADDR == rals_pkg::ADDR_STATUS
      |=> REG_RDATA[2] == $past(INPUT_CLOCK_PRESENT) && REG_RDATA[7:5] == 3'h0;
  endproperty
  a_clock_bit: assert property (p_clock_bit) else $error("clock detect bit wrong");

  property p_port_bank_read;
    @(posedge SYS_CLK) disable iff (!RESETN)
      REG_RD && REG_ADDR == rals_pkg::ADDR_CNT_HIGH && SECOND_PORT_SELECT
      |=> REG_RDATA == $past(bank_count[1][15:8]);
  endproperty
  a_port_bank_read: assert property (p_port_bank_read) else $error("wrong port read");

  property p_reserved_zero;
    @(posedge SYS_CLK) disable iff (!RESETN)
      REG_RD && (REG_ADDR == rals_pkg::ADDR_TARGET || REG_ADDR == rals_pkg::ADDR_ALIAS)
      |=> !REG_RDATA[0];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_reset_holds;
    @(posedge SYS_CLK) disable iff (!RESETN)
      CRC_COUNT_RESET [*2] |-> bank_count[0] == 16'h0000 && bank_count[1] == 16'h0000;
  endproperty
  a_reset_holds: assert property (p_reset_holds) else $error("counter ran under reset");

  c_remap:     cover property (@(posedge SYS_CLK) disable iff (!RESETN) FWD_VALID && FWD_PORT);
  c_link_lost: cover property (@(posedge SYS_CLK) disable iff (!RESETN) bank_link_lost[0]);
  c_count_hi:  cover property (@(posedge SYS_CLK) disable iff (!RESETN) bank_count[1][8]);
endmodule

/* File: tb/rals_remote_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// far side of the control channel: link level and crc events for each port
module rals_remote_model (
  input  wire logic  clk,                // events launch just after this edge
  output logic [1:0] link_detect,        // cable link level per port
  output logic [1:0] bc_crc_error,       // normal-mode crc error per port
  output logic [1:0] selftest_crc_error, // self-test crc error per port
  output logic [1:0] selftest_restart    // self-test restart per port
);
  // idle: no link, no events
  initial begin
    link_detect        = 2'h0;
    bc_crc_error       = 2'h0;
    selftest_crc_error = 2'h0;
    selftest_restart   = 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // link comes up or drops on a clock edge
  task automatic set_link(input int p, input logic v);
    @(posedge clk);
    link_detect[p] <= v;
  endtask

  // n back-to-back error cycles; a slow link gives one, a bad cable many
  task automatic errors(input int p, input int n, input logic st);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (st) begin
        selftest_crc_error[p] <= 1'b1;
      end else begin
        bc_crc_error[p] <= 1'b1;
      end
    end
    @(posedge clk);
    selftest_crc_error[p] <= 1'b0;
    bc_crc_error[p]       <= 1'b0;
  endtask

  // self-test restarts for one cycle
  task automatic restart(input int p);
    @(posedge clk);
    selftest_restart[p] <= 1'b1;
    @(posedge clk);
    selftest_restart[p] <= 1'b0;
  endtask
endmodule

/* File: tb/tb_rals_regs.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// self-checking bench for the alias, counter and status register slice
module tb_rals_regs;
  logic        clk;         // 200 MHz
  logic        resetn;      // synchronous, active low
  logic [7:0]  reg_addr;    // register offset
  logic        reg_wr;      // write strobe
  logic        reg_rd;      // read strobe
  logic [7:0]  reg_wdata;   // write data
  logic [7:0]  reg_rdata;   // read data
  logic        cnt_reset;   // counter-reset control bit
  logic        port_sel;    // second port select
  logic        clk_present; // video input clock level
  logic [1:0]  link, crc, st_crc, st_rst;
  logic        txn_valid;   // local transaction strobe
  logic [6:0]  txn_addr;    // local transaction address
  logic        fwd_valid, fwd_port, fwd_miss;
  logic [6:0]  fwd_addr;
  integer      seed = 32'h438F69FC;
  int          n_fail = 0;
  int          n_tests = 0;
  logic [6:0]  a0, a1, t0, t1;
  int          n0, n1;

  rals_regs dut (.SYS_CLK(clk), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .CRC_COUNT_RESET(cnt_reset), .SECOND_PORT_SELECT(port_sel),
    .INPUT_CLOCK_PRESENT(clk_present), .LINK_DETECT(link), .BC_CRC_ERROR(crc),
    .SELFTEST_CRC_ERROR(st_crc), .SELFTEST_RESTART(st_rst), .TXN_VALID(txn_valid),
    .TXN_ADDR(txn_addr), .FWD_VALID(fwd_valid), .FWD_ADDR(fwd_addr),
    .FWD_PORT(fwd_port), .FWD_MISS(fwd_miss));

  rals_remote_model remote (.clk(clk), .link_detect(link), .bc_crc_error(crc),
    .selftest_crc_error(st_crc), .selftest_restart(st_rst));

  ////////////////////////////////////////////////////////////////////////////
  // expected values
  function automatic logic [7:0] addr_byte(input logic [6:0] a);
    return {a, 1'b0};   // reserved bit 0 always reads zero
  endfunction
  function automatic logic [7:0] status(input logic lost, st, ck, ce, lk);
    return {3'h0, lost, st, ck, ce, lk};
  endfunction
  function automatic logic [6:0] rnd_addr();
    return 7'($unsigned($random(seed)) % 32'h7E + 32'h1);   // never zero
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // compare, bus cycles and verdict
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // strobe held for exactly one taken edge, data picked up after that edge
  task automatic wr(input logic p, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    port_sel  <= p;
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rchk(input logic p, input logic [7:0] a, input logic [7:0] e, string w);
    @(posedge clk);
    port_sel <= p;
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(w, 16'(e), 16'(reg_rdata));
  endtask
  // low and high byte read separately; no counting while they are read
  task automatic cnt_chk(input logic p, input logic [15:0] e);
    rchk(p, rals_pkg::ADDR_CNT_LOW, e[7:0], "count low");
    rchk(p, rals_pkg::ADDR_CNT_HIGH, e[15:8], "count high");
  endtask
  task automatic txn(input logic [6:0] a, input logic hit, input logic [6:0] t, input logic p);
    @(posedge clk);
    txn_valid <= 1'b1;
    txn_addr  <= a;
    @(posedge clk);
    txn_valid <= 1'b0;
    #1;
    chk("forward valid", 16'(hit), 16'(fwd_valid));
    chk("forward miss", 16'(!hit), 16'(fwd_miss));
    if (hit) begin
      chk("forward address", 16'(t), 16'(fwd_addr));
      chk("forward port", 16'(p), 16'(fwd_port));
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog; the saturation burst dominates the run time
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    resetn = 1'b0;  reg_addr = 8'h00;  reg_wr = 1'b0;  reg_rd = 1'b0;
    reg_wdata = 8'h00;  cnt_reset = 1'b0;  port_sel = 1'b0;  clk_present = 1'b0;
    txn_valid = 1'b0;  txn_addr = 7'h00;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    // reset values of every register in both banks
    for (int p = 0; p < 2; p++) begin
      rchk(p[0], rals_pkg::ADDR_TARGET, 8'h00, "target reset");
      rchk(p[0], rals_pkg::ADDR_ALIAS, 8'h00, "alias reset");
      cnt_chk(p[0], 16'h0000);
      rchk(p[0], rals_pkg::ADDR_STATUS, 8'h00, "status reset");
    end
    // random targets and aliases, bit 0 written as one
    a0 = rnd_addr();
    a1 = a0 + 7'h01;
    t0 = rnd_addr();
    t1 = rnd_addr();
    wr(1'b0, rals_pkg::ADDR_TARGET, {t0, 1'b1});
    wr(1'b0, rals_pkg::ADDR_ALIAS, {a0, 1'b1});
    wr(1'b1, rals_pkg::ADDR_TARGET, {t1, 1'b1});
    wr(1'b1, rals_pkg::ADDR_ALIAS, {a1, 1'b1});
    rchk(1'b0, rals_pkg::ADDR_TARGET, addr_byte(t0), "target port0");
    rchk(1'b0, rals_pkg::ADDR_ALIAS, addr_byte(a0), "alias port0");
    rchk(1'b1, rals_pkg::ADDR_TARGET, addr_byte(t1), "target port1");
    rchk(1'b1, rals_pkg::ADDR_ALIAS, addr_byte(a1), "alias port1");
    rchk(1'b0, 8'h09, 8'h00, "unmapped read");
    // remap on each port, then a stranger address
    txn(a0, 1'b1, t0, 1'b0);
    txn(a1, 1'b1, t1, 1'b1);
    txn(a0 ^ 7'h40, 1'b0, 7'h00, 1'b0);
    // zero target on port 0, zero alias on port 1: both refuse
    wr(1'b0, rals_pkg::ADDR_TARGET, 8'h00);
    wr(1'b1, rals_pkg::ADDR_ALIAS, 8'h00);
    txn(a0, 1'b0, 7'h00, 1'b0);
    txn(7'h00, 1'b0, 7'h00, 1'b0);
    // link and input clock, changed on a rising edge like every other input
    @(posedge clk);
    clk_present <= 1'b1;
    remote.set_link(0, 1'b1);
    rchk(1'b0, rals_pkg::ADDR_STATUS, status(0, 0, 1, 0, 1), "status port0");
    rchk(1'b1, rals_pkg::ADDR_STATUS, status(0, 0, 1, 0, 0), "status port1");
    // random error bursts: normal on port 0, self-test on port 1
    n0 = 1 + $unsigned($random(seed)) % 32'h14;
    n1 = 1 + $unsigned($random(seed)) % 32'h14;
    remote.errors(0, n0, 1'b0);
    remote.errors(1, n1, 1'b1);
    wr(1'b0, rals_pkg::ADDR_CNT_LOW, 8'h5A);   // read-only, ignored
    cnt_chk(1'b0, 16'(n0));
    cnt_chk(1'b1, 16'(n1));
    rchk(1'b0, rals_pkg::ADDR_STATUS, status(0, 0, 1, 1, 1), "status port0");
    rchk(1'b1, rals_pkg::ADDR_STATUS, status(0, 1, 1, 0, 0), "status port1");
    remote.restart(1);
    rchk(1'b1, rals_pkg::ADDR_STATUS, status(0, 0, 1, 0, 0), "status port1");
    // link loss clears error flags and sets the sticky flag
    remote.errors(0, 1, 1'b1);
    rchk(1'b0, rals_pkg::ADDR_STATUS, status(0, 1, 1, 1, 1), "status port0");
    remote.set_link(0, 1'b0);
    rchk(1'b0, rals_pkg::ADDR_STATUS, status(1, 0, 1, 0, 0), "status port0");
    remote.set_link(0, 1'b1);
    rchk(1'b0, rals_pkg::ADDR_STATUS, status(1, 0, 1, 0, 1), "status port0");
    cnt_chk(1'b0, 16'(n0 + 1));
    // counter reset clears both banks and holds them while set
    @(posedge clk);
    cnt_reset <= 1'b1;
    cnt_chk(1'b0, 16'h0000);
    cnt_chk(1'b1, 16'h0000);
    rchk(1'b0, rals_pkg::ADDR_STATUS, status(0, 0, 1, 0, 1), "status port0");
    remote.errors(0, 2, 1'b0);
    cnt_chk(1'b0, 16'h0000);
    @(posedge clk);
    cnt_reset <= 1'b0;
    remote.errors(0, 3, 1'b0);
    cnt_chk(1'b0, 16'h0003);
    // long burst on port 1 must stop at the top value
    remote.errors(1, 65540, 1'b0);
    cnt_chk(1'b1, rals_pkg::CNT_MAX);
    cnt_chk(1'b0, 16'h0003);
    print_verdict();
  end
endmodule
